// ===== rtl/dte_pkg.sv
// Constants, register layout and carrier types of the command timing enforcer
package dte_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] DTE_TIMING0_OFS = 12'h000;
  localparam logic [11:0] DTE_TIMING1_OFS = 12'h004;
  localparam logic [11:0] DTE_TIMING2_OFS = 12'h008;
  localparam logic [11:0] DTE_CONTROL_OFS = 12'h00c;
  localparam logic [11:0] DTE_STATUS_OFS  = 12'h010;

  // ----------------------------------------------------------------------
  // Field positions (lsb) and widths
  // ----------------------------------------------------------------------
  // timing_parameters_0
  localparam int unsigned ACT_PRE_LSB = 0,  ACT_PRE_W = 4;
  localparam int unsigned ROW_COL_LSB = 4,  ROW_COL_W = 4;
  localparam int unsigned WR_REC_LSB  = 8,  WR_REC_W  = 4;
  localparam int unsigned ROW_CYC_LSB = 12, ROW_CYC_W = 4;
  localparam int unsigned ROW_PRE_LSB = 16, ROW_PRE_W = 4;
  localparam int unsigned B2B_ACT_LSB = 20, B2B_ACT_W = 4;
  localparam int unsigned WR_RD_LSB   = 24, WR_RD_W   = 3;
  localparam int unsigned RED_WR_RD_BIT = 27;
  localparam int unsigned MODE_LD_LSB = 28, MODE_LD_W = 4;
  // timing_parameters_1
  localparam int unsigned REF_CYC_LSB = 0,  REF_CYC_W = 7;
  localparam int unsigned SRX_NRD_LSB = 8,  SRX_NRD_W = 8;
  localparam int unsigned SRX_RD_LSB  = 16, SRX_RD_W  = 8;
  localparam int unsigned PD_EXIT_LSB = 24, PD_EXIT_W = 4;
  // timing_parameters_2
  localparam int unsigned APD_FAST_LSB = 0,  APD_FAST_W = 4;
  localparam int unsigned APD_SLOW_LSB = 4,  APD_SLOW_W = 4;
  localparam int unsigned PRE_ALL_LSB  = 8,  PRE_ALL_W  = 4;
  localparam int unsigned RD_PRE_LSB   = 12, RD_PRE_W   = 3;
  localparam int unsigned FAW_LSB      = 16, FAW_W      = 4;
  // control register bits
  localparam int unsigned CTL_LP_LAT2_BIT   = 0;
  localparam int unsigned CTL_EIGHT_BANK_BIT = 1;
  localparam int unsigned CTL_APD_SLOW_BIT  = 2;

  // ----------------------------------------------------------------------
  // Reset values and fixed counts
  // ----------------------------------------------------------------------
  localparam logic [31:0] DTE_TIMING0_RST = 32'h22216226;
  localparam logic [31:0] DTE_TIMING1_RST = 32'h02d0100e;
  localparam logic [31:0] DTE_TIMING2_RST = 32'h000a2277;
  localparam logic [31:0] DTE_CONTROL_RST = 32'h00000002;
  localparam int unsigned DTE_BANKS       = 8;
  localparam int unsigned DTE_FAW_SLOTS   = 4;
  localparam logic [7:0]  DTE_BURST_CYC   = 8'h02;  // Write data clocks after a write

  // ----------------------------------------------------------------------
  // Commands and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    DTE_NOP  = 4'b0000,
    DTE_ACT  = 4'b0001,
    DTE_RD   = 4'b0010,
    DTE_WR   = 4'b0011,
    DTE_PRE  = 4'b0100,
    DTE_PREA = 4'b0101,
    DTE_REF  = 4'b0110,
    DTE_LMR  = 4'b0111,
    DTE_PDX  = 4'b1000,
    DTE_SRX  = 4'b1001,
    DTE_APDX = 4'b1010
  } dte_cmd_e;

  typedef struct packed {
    logic       valid;
    dte_cmd_e   cmd;
    logic [2:0] bank;
  } dte_req_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dte_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dte_apb_rsp_s;

endpackage : dte_pkg

// ===== rtl/dte_timing_enforcer.sv
// Command spacing enforcer for a DDR / DDR2 / low-power DDR SDRAM controller
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Precharge to a bank waits the active-to-precharge count after its Activate.
// - Read or Write waits the row-to-column count after the bank's Activate.
// - Precharge waits the write-recovery count after the last write data.
// - Activate waits the row-cycle count after an Activate to its bank; Refresh waits it after any Activate.
// - After a bank Precharge that bank takes nothing for the row-precharge count.
// - Activates to different banks are spaced by the bank-to-bank count.
// - Read waits the write-to-read count after a write burst.
// - Reduced write-to-read only for low-power latency 2 with the field at zero.
// - Activate or Refresh waits the mode-register count after Load Mode.
// - Any command waits the power-down exit count after a power-down or active power-down exit.
// - First Read waits the self-refresh-exit-to-read count.
// - Non-read commands wait the self-refresh-exit-to-non-read count.
// - Refresh or Activate waits the refresh-cycle count after Refresh.
// - Eight-bank parts: at most four Activates in the four-activate window.
// - Precharge waits the read-to-precharge count after a Read.
// - After Precharge All nothing issues for the precharge-all count.
// - Read after slow active power-down exit waits the slow-exit count.
// - Read after fast active power-down exit waits the fast-exit count.
// - Every delay is counted in cycles of the memory bus clock.
module dte_timing_enforcer (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // APB register port
  input  wire dte_pkg::dte_apb_req_s apb_req,
  output var  dte_pkg::dte_apb_rsp_s apb_rsp,
  // Command request from the scheduler
  input  wire dte_pkg::dte_req_s cmd_req,
  output logic                   cmd_ready,
  // Command released toward the SDRAM pins
  output var  dte_pkg::dte_req_s cmd_issued
);
  import dte_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef logic [DTE_BANKS-1:0][7:0] dte_bank_cnt_t;

  typedef struct packed {
    logic [31:0]    timing0;
    logic [31:0]    timing1;
    logic [31:0]    timing2;
    logic [31:0]    control;
    logic [31:0]    rdata;
    logic           slverr;
    dte_req_s       issued;
    logic           stalled;
    logic [DTE_BANKS-1:0] open;
    dte_bank_cnt_t  ras;     // Activate to precharge
    dte_bank_cnt_t  rcd;     // Activate to read/write
    dte_bank_cnt_t  wrp;     // Write data to precharge
    dte_bank_cnt_t  rtp;     // Read to precharge
    dte_bank_cnt_t  rp;      // Precharge to any command in that bank
    dte_bank_cnt_t  rc;      // Activate to activate/refresh
    logic [7:0]     rrd;
    logic [7:0]     wtr;
    logic [7:0]     mrd;
    logic [7:0]     xp;
    logic [7:0]     xsrd;
    logic [7:0]     xsnr;
    logic [7:0]     rfc;
    logic [7:0]     rpa;
    logic [7:0]     xard;
    logic [DTE_FAW_SLOTS-1:0][7:0] faw;
  } dte_state_s;

  dte_state_s state_reg;
  dte_state_s state_next;
  logic       cmd_ok;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Extract a timing field, zero-extended to counter width
  function automatic logic [7:0] fld(input logic [31:0] r, input int unsigned lsb,
                                     input int unsigned w);
    logic [31:0] m;
    m = (32'h1 << w) - 32'h1;
    fld = 8'((r >> lsb) & m);
  endfunction : fld

  // A count of N lets the gated command go N cycles later
  function automatic logic [7:0] ld(input logic [7:0] n);
    ld = (n == 8'h00) ? 8'h00 : n - 8'h01;
  endfunction : ld

  function automatic logic [7:0] dec(input logic [7:0] c);
    dec = ld(c);
  endfunction : dec

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Counters only ever count mclk edges, which is the memory bus clock
  always_comb begin
    logic        ras_clr;
    logic        wr_clr;
    logic        rtp_clr;
    logic        rp_clr;
    logic        rc_clr;
    logic        faw_ok;
    logic        faw_en;
    logic        red_wr_rd;
    logic        gen_ok;
    logic        rd_gate_ok;
    logic        slot_found;
    logic [2:0]  b;
    logic [11:0] a;
    logic [7:0]  wtr_ld;
    ras_clr    = 1'b1;
    wr_clr     = 1'b1;
    rtp_clr    = 1'b1;
    rp_clr     = 1'b1;
    rc_clr     = 1'b1;
    faw_ok     = 1'b0;
    slot_found = 1'b0;
    {faw_en, red_wr_rd, gen_ok, rd_gate_ok, wtr_ld} = '0;
    b          = cmd_req.bank;
    a          = apb_req.paddr;
    state_next = state_reg;

    // Aggregates over all banks for the all-bank commands
    for (int i = 0; i < DTE_BANKS; i++) begin
      ras_clr = ras_clr & (state_reg.ras[i] == 8'h00);
      wr_clr  = wr_clr  & (state_reg.wrp[i] == 8'h00);
      rtp_clr = rtp_clr & (state_reg.rtp[i] == 8'h00);
      rp_clr  = rp_clr  & (state_reg.rp[i]  == 8'h00);
      rc_clr  = rc_clr  & (state_reg.rc[i]  == 8'h00);
    end
    for (int k = 0; k < DTE_FAW_SLOTS; k++) begin
      faw_ok = faw_ok | (state_reg.faw[k] == 8'h00);
    end
    faw_en = state_reg.control[CTL_EIGHT_BANK_BIT];

    // Reduced spacing needs low-power latency 2 and a zero field
    red_wr_rd = state_reg.timing0[RED_WR_RD_BIT] & state_reg.control[CTL_LP_LAT2_BIT] &
                (fld(state_reg.timing0, WR_RD_LSB, WR_RD_W) == 8'h00);

    // Exit gates shared by most commands
    gen_ok     = (state_reg.xp == 8'h00) &
                 (state_reg.xsnr == 8'h00) &
                 (state_reg.rpa == 8'h00);
    rd_gate_ok = (state_reg.xp == 8'h00) &
                 (state_reg.xsrd == 8'h00) &
                 (state_reg.xard == 8'h00) &
                 (state_reg.rpa == 8'h00);

    // Issue decision: a pending command waits for every counter it needs
    unique case (cmd_req.cmd)
      DTE_NOP:  cmd_ok = 1'b1;
      DTE_ACT:  cmd_ok = gen_ok & (state_reg.rc[b] == 8'h00) &
                         (state_reg.rp[b] == 8'h00) &
                         (state_reg.rrd == 8'h00) &
                         (state_reg.mrd == 8'h00) &
                         (state_reg.rfc == 8'h00) &
                         (faw_ok | ~faw_en);
      DTE_RD:   cmd_ok = rd_gate_ok & (state_reg.rcd[b] == 8'h00) &
                         (state_reg.rp[b] == 8'h00) &
                         (state_reg.wtr == 8'h00);
      DTE_WR:   cmd_ok = gen_ok & (state_reg.rcd[b] == 8'h00) &
                         (state_reg.rp[b] == 8'h00);
      DTE_PRE:  cmd_ok = gen_ok & (state_reg.ras[b] == 8'h00) &
                         (state_reg.wrp[b] == 8'h00) &
                         (state_reg.rtp[b] == 8'h00) &
                         (state_reg.rp[b] == 8'h00);
      DTE_PREA: cmd_ok = gen_ok & ras_clr & wr_clr & rtp_clr & rp_clr;
      DTE_REF:  cmd_ok = gen_ok & rc_clr & rp_clr &
                         (state_reg.mrd == 8'h00) &
                         (state_reg.rfc == 8'h00);
      DTE_LMR:  cmd_ok = gen_ok & rp_clr & (state_reg.rfc == 8'h00) &
                         (state_reg.mrd == 8'h00);
      DTE_PDX, DTE_SRX, DTE_APDX: cmd_ok = 1'b1;  // Raising CKE needs no spacing
      default:  cmd_ok = 1'b0;                    // Unknown codes never issue
    endcase

    // Every interval counts down by one per clock
    for (int i = 0; i < DTE_BANKS; i++) begin
      state_next.ras[i] = dec(state_reg.ras[i]);
      state_next.rcd[i] = dec(state_reg.rcd[i]);
      state_next.wrp[i] = dec(state_reg.wrp[i]);
      state_next.rtp[i] = dec(state_reg.rtp[i]);
      state_next.rp[i]  = dec(state_reg.rp[i]);
      state_next.rc[i]  = dec(state_reg.rc[i]);
    end
    for (int k = 0; k < DTE_FAW_SLOTS; k++) begin
      state_next.faw[k] = dec(state_reg.faw[k]);
    end
    state_next.rrd  = dec(state_reg.rrd);
    state_next.wtr  = dec(state_reg.wtr);
    state_next.mrd  = dec(state_reg.mrd);
    state_next.xp   = dec(state_reg.xp);
    state_next.xsrd = dec(state_reg.xsrd);
    state_next.xsnr = dec(state_reg.xsnr);
    state_next.rfc  = dec(state_reg.rfc);
    state_next.rpa  = dec(state_reg.rpa);
    state_next.xard = dec(state_reg.xard);

    // Write-to-read spans the burst; reduced mode lets the read go on the next clock after the write
    wtr_ld = red_wr_rd ? 8'h00 :
             ld(DTE_BURST_CYC + fld(state_reg.timing0, WR_RD_LSB, WR_RD_W));

    // Restart the counters that the issued command opens
    state_next.issued.valid = cmd_req.valid & cmd_ok;
    state_next.issued.cmd   = cmd_req.cmd;
    state_next.issued.bank  = cmd_req.bank;
    state_next.stalled      = cmd_req.valid & ~cmd_ok;
    if (cmd_req.valid && cmd_ok) begin
      unique case (cmd_req.cmd)
        DTE_ACT: begin
          state_next.open[b] = 1'b1;
          state_next.ras[b]  = ld(fld(state_reg.timing0, ACT_PRE_LSB, ACT_PRE_W));
          state_next.rcd[b]  = ld(fld(state_reg.timing0, ROW_COL_LSB, ROW_COL_W));
          state_next.rc[b]   = ld(fld(state_reg.timing0, ROW_CYC_LSB, ROW_CYC_W));
          state_next.rrd     = ld(fld(state_reg.timing0, B2B_ACT_LSB, B2B_ACT_W));
          // Lowest-numbered expired slot takes this activate
          for (int k = 0; k < DTE_FAW_SLOTS; k++) begin
            if (!slot_found && state_reg.faw[k] == 8'h00) begin
              slot_found        = 1'b1;
              state_next.faw[k] = ld(fld(state_reg.timing2, FAW_LSB, FAW_W));
            end
          end
        end
        DTE_RD: begin
          state_next.rtp[b] = ld(fld(state_reg.timing2, RD_PRE_LSB, RD_PRE_W));
        end
        DTE_WR: begin
          // Recovery starts after the burst's last data clock
          state_next.wrp[b] = ld(DTE_BURST_CYC +
                                 fld(state_reg.timing0, WR_REC_LSB, WR_REC_W));
          state_next.wtr    = wtr_ld;
        end
        DTE_PRE: begin
          state_next.open[b] = 1'b0;
          state_next.rp[b]   = ld(fld(state_reg.timing0, ROW_PRE_LSB, ROW_PRE_W));
        end
        DTE_PREA: begin
          state_next.open = '0;
          state_next.rpa  = ld(fld(state_reg.timing2, PRE_ALL_LSB, PRE_ALL_W));
        end
        DTE_REF: begin
          state_next.rfc = ld(fld(state_reg.timing1, REF_CYC_LSB, REF_CYC_W));
        end
        DTE_LMR: begin
          state_next.mrd = ld(fld(state_reg.timing0, MODE_LD_LSB, MODE_LD_W));
        end
        DTE_PDX: begin
          state_next.xp = ld(fld(state_reg.timing1, PD_EXIT_LSB, PD_EXIT_W));
        end
        DTE_SRX: begin
          state_next.xsrd = ld(fld(state_reg.timing1, SRX_RD_LSB, SRX_RD_W));
          state_next.xsnr = ld(fld(state_reg.timing1, SRX_NRD_LSB, SRX_NRD_W));
        end
        DTE_APDX: begin
          // Exit mode picks the read spacing
          state_next.xp = ld(fld(state_reg.timing1, PD_EXIT_LSB, PD_EXIT_W));
          if (state_reg.control[CTL_APD_SLOW_BIT]) begin
            state_next.xard = ld(fld(state_reg.timing2, APD_SLOW_LSB, APD_SLOW_W));
          end else begin
            state_next.xard = ld(fld(state_reg.timing2, APD_FAST_LSB, APD_FAST_W));
          end
        end
        default: state_next.open = state_reg.open;
      endcase
    end

    // APB: read data and error are captured in the setup phase
    if (apb_req.psel && !apb_req.penable) begin
      state_next.slverr = 1'b0;
      unique case (a)
        DTE_TIMING0_OFS: state_next.rdata = state_reg.timing0;
        DTE_TIMING1_OFS: state_next.rdata = state_reg.timing1;
        DTE_TIMING2_OFS: state_next.rdata = state_reg.timing2;
        DTE_CONTROL_OFS: state_next.rdata = state_reg.control;
        DTE_STATUS_OFS:  state_next.rdata = {16'h0000, state_reg.open, 6'h00,
                                             state_reg.stalled,
                                             ras_clr & wr_clr & rtp_clr & rp_clr & rc_clr};
        default: begin
          state_next.rdata  = 32'h00000000;
          state_next.slverr = 1'b1;
        end
      endcase
    end

    // APB writes land in the access phase; status is read-only
    if (apb_req.psel && apb_req.penable && apb_req.pwrite) begin
      unique case (a)
        DTE_TIMING0_OFS: state_next.timing0 = apb_req.pwdata;
        DTE_TIMING1_OFS: state_next.timing1 = apb_req.pwdata;
        DTE_TIMING2_OFS: state_next.timing2 = apb_req.pwdata;
        DTE_CONTROL_OFS: state_next.control = {29'h00000000, apb_req.pwdata[2:0]};
        default:         state_next.control = state_reg.control;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset leaves every interval expired and safe default timings
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg         <= '0;
      state_reg.timing0 <= DTE_TIMING0_RST;
      state_reg.timing1 <= DTE_TIMING1_RST;
      state_reg.timing2 <= DTE_TIMING2_RST;
      state_reg.control <= DTE_CONTROL_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Ready is combinational so an expired interval costs no extra clock
  assign cmd_ready       = cmd_ok;
  assign cmd_issued      = state_reg.issued;
  assign apb_rsp.prdata  = state_reg.rdata;
  assign apb_rsp.pslverr = state_reg.slverr & apb_req.psel & apb_req.penable;
  assign apb_rsp.pready  = 1'b1;

endmodule : dte_timing_enforcer

`default_nettype wire

// ===== tb/dte_sdram_model.sv
// Passive SDRAM-side model that times the spacing of issued commands
`timescale 1ns/1ps
`default_nettype none
module dte_sdram_model (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Commands seen on the SDRAM pins
  input  wire dte_pkg::dte_req_s cmd_issued,
  output var  logic [15:0]       last_gap
);
  import dte_pkg::*;
  logic [15:0] cyc_reg;
  logic [15:0] prev_reg;

  // The device only ever sees memory bus clocks, so gaps are in those cycles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_reg  <= '0;
      prev_reg <= '0;
      last_gap <= '0;
    end else begin
      cyc_reg <= cyc_reg + 16'h0001;
      if (cmd_issued.valid) begin
        last_gap <= cyc_reg - prev_reg;
        prev_reg <= cyc_reg;
      end
    end
  end
endmodule : dte_sdram_model
`default_nettype wire

// ===== tb/dte_timing_enforcer_monitor.sv
// Concurrent checks on the ports of the command timing enforcer
`timescale 1ns/1ps
`default_nettype none
module dte_timing_enforcer_monitor (
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  rst_n,
  // Register port
  input wire dte_pkg::dte_apb_req_s apb_req,
  input wire dte_pkg::dte_apb_rsp_s apb_rsp,
  // Command path
  input wire dte_pkg::dte_req_s     cmd_req,
  input wire logic                  cmd_ready,
  input wire dte_pkg::dte_req_s     cmd_issued
);
  import dte_pkg::*;
  logic [31:0] t0_reg;
  logic [31:0] t1_reg;
  logic [7:0]  act_age_reg;
  logic [7:0]  ref_age_reg;
  logic [2:0]  act_bank_reg;
  logic        acc;
  logic        apb_acc;
  assign acc     = cmd_req.valid && cmd_ready;
  assign apb_acc = apb_req.psel && apb_req.penable;

  // Zero counts behave as one cycle
  function automatic logic [7:0] mx(logic [7:0] n);
    return (n == 8'h00) ? 8'h01 : n;
  endfunction : mx

  // Shadow timing words; ages saturate so stale commands never look recent
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      t0_reg       <= DTE_TIMING0_RST;
      t1_reg       <= DTE_TIMING1_RST;
      act_age_reg  <= 8'hff;
      ref_age_reg  <= 8'hff;
      act_bank_reg <= 3'h0;
    end else begin
      if (apb_acc && apb_req.pwrite && apb_req.paddr == DTE_TIMING0_OFS) t0_reg <= apb_req.pwdata;
      if (apb_acc && apb_req.pwrite && apb_req.paddr == DTE_TIMING1_OFS) t1_reg <= apb_req.pwdata;
      act_age_reg <= (acc && cmd_req.cmd == DTE_ACT) ? 8'h01 :
                     (act_age_reg == 8'hff) ? act_age_reg : act_age_reg + 8'h01;
      ref_age_reg <= (acc && cmd_req.cmd == DTE_REF) ? 8'h01 :
                     (ref_age_reg == 8'hff) ? ref_age_reg : ref_age_reg + 8'h01;
      if (acc && cmd_req.cmd == DTE_ACT) act_bank_reg <= cmd_req.bank;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_issue_follows_accept: assert property (acc |=> cmd_issued == $past(cmd_req))
    else $error("accepted command not issued next cycle");
  a_no_spurious_issue: assert property (!acc |=> !cmd_issued.valid)
    else $error("command issued without acceptance");
  a_row_col_gap: assert property (acc && (cmd_req.cmd == DTE_RD || cmd_req.cmd == DTE_WR) &&
    cmd_req.bank == act_bank_reg |-> act_age_reg >= mx(8'(t0_reg[ROW_COL_LSB +: ROW_COL_W])))
    else $error("read or write too soon after activate");
  a_act_pre_gap: assert property (acc && cmd_req.cmd == DTE_PRE &&
    cmd_req.bank == act_bank_reg |-> act_age_reg >= mx(8'(t0_reg[ACT_PRE_LSB +: ACT_PRE_W])))
    else $error("precharge too soon after activate");
  a_bank_act_gap: assert property (acc && cmd_req.cmd == DTE_ACT |->
    act_age_reg >= mx(8'(t0_reg[B2B_ACT_LSB +: B2B_ACT_W])))
    else $error("activates too close together");
  a_row_cycle_gap: assert property (acc && (cmd_req.cmd == DTE_REF ||
    (cmd_req.cmd == DTE_ACT && cmd_req.bank == act_bank_reg)) |->
    act_age_reg >= mx(8'(t0_reg[ROW_CYC_LSB +: ROW_CYC_W])))
    else $error("row cycle count not met");
  a_refresh_gap: assert property (acc && (cmd_req.cmd == DTE_REF || cmd_req.cmd == DTE_ACT) |->
    ref_age_reg >= mx(8'(t1_reg[REF_CYC_LSB +: REF_CYC_W])))
    else $error("refresh cycle count not met");
  a_unmapped_err: assert property (apb_acc && apb_req.paddr > DTE_STATUS_OFS |->
    apb_rsp.pslverr && (apb_req.pwrite || apb_rsp.prdata == 32'h00000000))
    else $error("unmapped access not refused");
  a_mapped_no_err: assert property (apb_acc && apb_req.paddr <= DTE_STATUS_OFS |->
    apb_rsp.pready && !apb_rsp.pslverr)
    else $error("mapped access refused or stalled");

  c_activate: cover property (acc && cmd_req.cmd == DTE_ACT);
  c_refresh: cover property (acc && cmd_req.cmd == DTE_REF);
  c_stall: cover property (cmd_req.valid && !cmd_ready);
  c_apb_error: cover property (apb_acc && apb_rsp.pslverr);
endmodule : dte_timing_enforcer_monitor

bind dte_timing_enforcer dte_timing_enforcer_monitor i_mon (.mclk(mclk), .rst_n(rst_n),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .cmd_req(cmd_req), .cmd_ready(cmd_ready),
  .cmd_issued(cmd_issued));
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking testbench for the command timing enforcer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dte_pkg::*;
  localparam logic [31:0] T0 = DTE_TIMING0_RST;
  localparam logic [31:0] T1 = DTE_TIMING1_RST;
  localparam logic [31:0] T2 = DTE_TIMING2_RST;
  logic         mclk;
  logic         rst_n;
  dte_apb_req_s apb_req;
  dte_apb_rsp_s apb_rsp;
  dte_req_s     cmd_req;
  logic         cmd_ready;
  dte_req_s     cmd_issued;
  logic [15:0]  last_gap;
  logic [31:0]  rd;
  logic         err;
  int           n_mismatch = 0;
  int           n_checks = 0;
  int           cyc = 0;

  dte_timing_enforcer i_dut (.mclk(mclk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .cmd_req(cmd_req), .cmd_ready(cmd_ready), .cmd_issued(cmd_issued));
  dte_sdram_model i_mem (.mclk(mclk), .rst_n(rst_n), .cmd_issued(cmd_issued), .last_gap(last_gap));

  // 100 MHz memory bus clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // Hang guard; the planned run is about 5500 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One APB transfer, then one idle edge
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    do @(posedge mclk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge mclk);
  endtask : apb

  // Holds the command until the edge that accepts it
  task automatic send(dte_cmd_e c, logic [2:0] b);
    cmd_req <= '{1'b1, c, b};
    do @(posedge mclk); while (cmd_ready !== 1'b1);
  endtask : send

  task automatic idle(int n);
    cmd_req <= '0;
    repeat (n) @(posedge mclk);
  endtask : idle

  // Long idle first so every count has run out
  task automatic pair(string what, dte_cmd_e c1, dte_cmd_e c2, logic [2:0] b2, int exp);
    idle(250);
    send(c1, 3'd0);
    send(c2, b2);
    idle(3);
    chk(what, 32'(last_gap), 32'(exp));
  endtask : pair

  task automatic t_regs;
    apb(1'b0, DTE_TIMING0_OFS, '0);
    chk("timing0 reset", rd, T0);
    apb(1'b0, DTE_TIMING1_OFS, '0);
    chk("timing1 reset", rd, T1);
    apb(1'b0, DTE_TIMING2_OFS, '0);
    chk("timing2 reset", rd, T2);
    apb(1'b1, DTE_TIMING0_OFS, 32'h5a5a5a5a);
    apb(1'b0, DTE_TIMING0_OFS, '0);
    chk("timing0 rw", rd, 32'h5a5a5a5a);
    apb(1'b1, DTE_TIMING0_OFS, T0);
    apb(1'b0, 12'h020, '0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_bank;
    pair("act to read", DTE_ACT, DTE_RD, 3'd0, T0[ROW_COL_LSB +: ROW_COL_W]);
    pair("act to pre", DTE_ACT, DTE_PRE, 3'd0, T0[ACT_PRE_LSB +: ACT_PRE_W]);
    pair("pre to act", DTE_PRE, DTE_ACT, 3'd0, T0[ROW_PRE_LSB +: ROW_PRE_W]);
    pair("act to act", DTE_ACT, DTE_ACT, 3'd1, T0[B2B_ACT_LSB +: B2B_ACT_W]);
    $display("t_bank done");
  endtask : t_bank

  task automatic t_rows;
    pair("act to ref", DTE_ACT, DTE_REF, 3'd0, T0[ROW_CYC_LSB +: ROW_CYC_W]);
    pair("ref to ref", DTE_REF, DTE_REF, 3'd0, T1[REF_CYC_LSB +: REF_CYC_W]);
    pair("lmr to act", DTE_LMR, DTE_ACT, 3'd0, T0[MODE_LD_LSB +: MODE_LD_W]);
    pair("prea to act", DTE_PREA, DTE_ACT, 3'd0, T2[PRE_ALL_LSB +: PRE_ALL_W]);
    $display("t_rows done");
  endtask : t_rows

  task automatic t_exits;
    pair("pdx to act", DTE_PDX, DTE_ACT, 3'd0, T1[PD_EXIT_LSB +: PD_EXIT_W]);
    pair("srx to read", DTE_SRX, DTE_RD, 3'd0, T1[SRX_RD_LSB +: SRX_RD_W]);
    pair("srx to act", DTE_SRX, DTE_ACT, 3'd0, T1[SRX_NRD_LSB +: SRX_NRD_W]);
    pair("fast exit", DTE_APDX, DTE_RD, 3'd0, T2[APD_FAST_LSB +: APD_FAST_W]);
    apb(1'b1, DTE_TIMING2_OFS, 32'h000a2297);
    apb(1'b1, DTE_CONTROL_OFS, 32'h00000006);
    pair("slow exit", DTE_APDX, DTE_RD, 3'd0, 9);
    apb(1'b1, DTE_TIMING2_OFS, T2);
    apb(1'b1, DTE_CONTROL_OFS, DTE_CONTROL_RST);
    $display("t_exits done");
  endtask : t_exits

  task automatic t_write;
    pair("wr to pre", DTE_WR, DTE_PRE, 3'd0, T0[WR_REC_LSB +: WR_REC_W] + DTE_BURST_CYC);
    pair("wr to rd", DTE_WR, DTE_RD, 3'd0, T0[WR_RD_LSB +: WR_RD_W] + DTE_BURST_CYC);
    pair("rd to pre", DTE_RD, DTE_PRE, 3'd0, T2[RD_PRE_LSB +: RD_PRE_W]);
    apb(1'b1, DTE_TIMING0_OFS, 32'h28216226);
    apb(1'b1, DTE_CONTROL_OFS, 32'h00000003);
    pair("reduced wr to rd", DTE_WR, DTE_RD, 3'd0, 1);
    apb(1'b1, DTE_TIMING0_OFS, T0);
    apb(1'b1, DTE_CONTROL_OFS, DTE_CONTROL_RST);
    $display("t_write done");
  endtask : t_write

  // Fifth activate waits for the window, not the bank-to-bank count
  task automatic t_faw;
    idle(250);
    for (int b = 0; b < 4; b++) begin
      send(DTE_ACT, 3'(b));
    end
    send(DTE_ACT, 3'd4);
    idle(3);
    chk("fifth act", 32'(last_gap), 32'(T2[FAW_LSB +: FAW_W] - 3 * T0[B2B_ACT_LSB +: B2B_ACT_W]));
    $display("t_faw done");
  endtask : t_faw

  task automatic t_reprog;
    apb(1'b1, DTE_TIMING0_OFS, 32'h22216256);
    pair("rcd five", DTE_ACT, DTE_RD, 3'd0, 5);
    apb(1'b1, DTE_TIMING0_OFS, 32'h22216206);
    pair("rcd zero", DTE_ACT, DTE_RD, 3'd0, 1);
    $display("t_reprog done");
  endtask : t_reprog

  // Main sequence
  initial begin
    rst_n = 1'b0;
    apb_req = '0;
    cmd_req = '0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_bank();
    t_rows();
    t_exits();
    t_write();
    t_faw();
    t_reprog();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
